// ### hdl/pc_stack_map.svh
`ifndef PC_STACK_MAP_SVH
`define PC_STACK_MAP_SVH

// Register byte offsets on the APB
`define PCS_OFS_PC_LOW 12'h000
`define PCS_OFS_HIGH_LATCH 12'h004
`define PCS_OFS_FLOW_CFG 12'h008

// Reset values
`define PCS_RST_PC 13'h0000
`define PCS_RST_HIGH_LATCH 5'h00
`define PCS_RST_FLOW_CFG 1'h0

// Field positions
`define PCS_LOW_MSB 7
`define PCS_TGT_MSB 10
`define PCS_PAGE_MSB 4
`define PCS_PAGE_LSB 3
`define PCS_LATCH_MSB 4
`define PCS_CFG_PAGE_BIT 0

// Step of the counter
`define PCS_PC_STEP 13'h0001

`endif

// ### hdl/pc_stack_pkg.sv
package pc_stack_pkg;

  // Control requests from the decoder and interrupt logic, one cycle each
  typedef struct packed {
    logic step;
    logic jump;
    logic call;
    logic ret;
    logic vector;
    logic [10:0] target;
  } flow_req_s;

  // Source selected for the next counter value
  typedef enum logic [2:0] {
    PC_HOLD = 3'b000,
    PC_STEP = 3'b001,
    PC_BRANCH = 3'b010,
    PC_POP = 3'b011,
    PC_VECTOR = 3'b100,
    PC_LOW_WRITE = 3'b101
  } pc_src_e;

  // APB response carried as one group
  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
  } apb_rsp_s;

endpackage

// ### hdl/return_stack.sv
`timescale 1ns/1ns
// Circular return-address stack; the pointer wraps silently both ways
module return_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic [WIDTH-1:0] top_o
);

  localparam int PW = $clog2(DEPTH);

  // Power-of-two depth keeps the wrap a plain binary roll-over
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("return_stack: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_reg;
  logic [PW-1:0] ptr_next;
  logic wr_en;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer arithmetic; no overflow or underflow flag exists
  always_comb begin
    ptr_next = ptr_reg;
    wr_en = 1'h0;
    if (ce_i && push_i) begin
      wr_en = 1'h1;
      ptr_next = ptr_reg + PW'(1);
    end else if (ce_i && pop_i) begin
      ptr_next = ptr_reg - PW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_reg <= '0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // Storage needs no reset; ninth push lands on the first slot again
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[ptr_reg] <= push_data_i;
    end
  end

  // Top of stack is the slot just below the pointer, wrapped
  assign top_o = mem[ptr_reg - PW'(1)];

endmodule // return_stack

// ### hdl/program_counter_and_call_stack.sv
`timescale 1ns/1ns
`include "pc_stack_map.svh"

module program_counter_and_call_stack #(
  parameter int PC_WIDTH = 13,
  parameter int STACK_DEPTH = 8,
  parameter logic [12:0] VECTOR_ADDR = 13'h0004,
  parameter bit PAGE_BITS_FITTED = 1'h0
) (
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  // Decoder and interrupt requests
  input wire logic STEP_I,
  input wire logic JUMP_I,
  input wire logic CALL_I,
  input wire logic RET_I,
  input wire logic VECTOR_I,
  input wire logic [10:0] TARGET_I,
  output logic [12:0] PC_O,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  // The page arithmetic below assumes the documented widths
  initial begin
    if (PC_WIDTH != 13) begin
      $error("program_counter_and_call_stack: PC_WIDTH must be 13");
    end
    if (STACK_DEPTH < 2) begin
      $error("program_counter_and_call_stack: STACK_DEPTH too small");
    end
    // Non-power-of-two depths would break the silent wrap
    if ((STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin
      $error("program_counter_and_call_stack: STACK_DEPTH must be a power of two");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Request word and the counter source it selects
  pc_stack_pkg::flow_req_s req;
  pc_stack_pkg::pc_src_e pc_src;
  // Bus response, captured at the setup edge
  pc_stack_pkg::apb_rsp_s rsp_reg;
  pc_stack_pkg::apb_rsp_s rsp_next;

  // Software-visible state; the stack pointer stays inside the stack
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic [4:0] high_latch_reg;
  logic [4:0] high_latch_next;
  logic page_en_reg;
  logic page_en_next;

  // Stack and branch paths
  logic [12:0] stack_top;
  logic [12:0] branch_addr;
  logic push;
  logic pop;

  // Bus phase and write strobes
  logic setup;
  logic access;
  logic wr_take;
  logic low_wr;
  logic latch_wr;
  logic cfg_wr;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Address decode shared by the read mux and the write strobes
  // Limitation: exact match only, so no register has an alias
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Jump and call target: 11-bit field plus two page bits
  // Page forced to zero unless fitted and enabled by software
  function automatic logic [12:0] form_target(
    input logic [10:0] field,
    input logic [4:0] latch,
    input logic page_use
  );
    logic [1:0] page;
    page = 2'h0;
    if (page_use) begin
      page = latch[`PCS_PAGE_MSB:`PCS_PAGE_LSB];
    end
    form_target = {page, field};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request grouping and bus phase decode

  // Requests come from logic on this clock, so no synchroniser
  // Packing the strobes keeps the priority chain in one place
  assign req.step = STEP_I;
  assign req.jump = JUMP_I;
  assign req.call = CALL_I;
  assign req.ret = RET_I;
  assign req.vector = VECTOR_I;
  assign req.target = TARGET_I;

  // Setup captures the answer, access commits the write
  assign setup = PSEL_I && !PENABLE_I;
  assign access = PSEL_I && PENABLE_I;
  // Writes take effect at the access edge, only with the low lane strobed
  assign wr_take = access && PWRITE_I && PSTRB_I[0] && CE_I;
  assign low_wr = wr_take && hit(PADDR_I, `PCS_OFS_PC_LOW);
  assign latch_wr = wr_take && hit(PADDR_I, `PCS_OFS_HIGH_LATCH);
  assign cfg_wr = wr_take && hit(PADDR_I, `PCS_OFS_FLOW_CFG);
  // Anything else answers with an error and writes nothing
  assign mapped = hit(PADDR_I, `PCS_OFS_PC_LOW) || hit(PADDR_I, `PCS_OFS_HIGH_LATCH)
    || hit(PADDR_I, `PCS_OFS_FLOW_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Counter source selection

  // Flow changes outrank a low-byte write, which outranks a plain step.
  // Vectoring first: an interrupt accepted in a cycle preempts the rest.
  // Hazard: a low-byte write beside a flow op is lost, not deferred.
  always_comb begin
    if (req.vector) begin
      pc_src = pc_stack_pkg::PC_VECTOR;
    end else if (req.ret) begin
      pc_src = pc_stack_pkg::PC_POP;
    end else if (req.jump || req.call) begin
      pc_src = pc_stack_pkg::PC_BRANCH;
    end else if (low_wr) begin
      pc_src = pc_stack_pkg::PC_LOW_WRITE;
    end else if (req.step) begin
      pc_src = pc_stack_pkg::PC_STEP;
    end else begin
      pc_src = pc_stack_pkg::PC_HOLD;
    end
  end

  // Page bits live on only where the variant fits them
  assign branch_addr = form_target(req.target, high_latch_reg,
    PAGE_BITS_FITTED && page_en_reg);

  // Calls and vectoring push the full counter; returns pop it
  assign push = CE_I && ((pc_src == pc_stack_pkg::PC_VECTOR)
    || ((pc_src == pc_stack_pkg::PC_BRANCH) && req.call));
  // Pop needs no empty check; an unmatched return wraps silently
  assign pop = CE_I && (pc_src == pc_stack_pkg::PC_POP);

  ////////////////////////////////////////////////////////////////////////////
  // Next counter value

  // Hold is the default; a frozen enable forces hold again after the case
  always_comb begin
    pc_next = pc_reg;
    case (pc_src)
      pc_stack_pkg::PC_STEP: begin
        pc_next = pc_reg + `PCS_PC_STEP;
      end
      pc_stack_pkg::PC_BRANCH: begin
        pc_next = branch_addr;
      end
      pc_stack_pkg::PC_POP: begin
        pc_next = stack_top;
      end
      pc_stack_pkg::PC_VECTOR: begin
        pc_next = VECTOR_ADDR;
      end
      pc_stack_pkg::PC_LOW_WRITE: begin
        // Upper bits only ever come from the latch
        // Latch value is the one before any write in the same cycle
        pc_next = {high_latch_reg, PWDATA_I[`PCS_LOW_MSB:0]};
      end
      pc_stack_pkg::PC_HOLD: begin
        pc_next = pc_reg;
      end
      default: begin
        pc_next = pc_reg;
      end
    endcase
    if (!CE_I) begin
      pc_next = pc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible state next values

  // Only bus writes touch the latch; stack traffic never does
  // Config bit only matters where the page bits are fitted
  always_comb begin
    high_latch_next = high_latch_reg;
    page_en_next = page_en_reg;
    if (latch_wr) begin
      high_latch_next = PWDATA_I[`PCS_LATCH_MSB:0];
    end
    if (cfg_wr) begin
      page_en_next = PWDATA_I[`PCS_CFG_PAGE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response, captured in the setup phase

  // Read data registered one phase early keeps the slave at zero wait.
  // Limitation: a read returns the counter as it stood at the setup edge.
  // A write setup still clears rdata, so no stale read leaks out.
  always_comb begin
    rsp_next = rsp_reg;
    if (setup && CE_I) begin
      rsp_next.rdata = 32'h0000_0000;
      rsp_next.slverr = !mapped;
      if (!PWRITE_I) begin
        if (hit(PADDR_I, `PCS_OFS_PC_LOW)) begin
          rsp_next.rdata[`PCS_LOW_MSB:0] = pc_reg[`PCS_LOW_MSB:0];
        end else if (hit(PADDR_I, `PCS_OFS_HIGH_LATCH)) begin
          rsp_next.rdata[`PCS_LATCH_MSB:0] = high_latch_reg;
        end else if (hit(PADDR_I, `PCS_OFS_FLOW_CFG)) begin
          rsp_next.rdata[`PCS_CFG_PAGE_BIT] = page_en_reg;
        end else begin
          rsp_next.rdata = 32'h0000_0000;
        end
      end
      // Stack pointer has no address, so it can never be read
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // One bank for all software-visible state; CE_I is already folded in
  // Reset loads constants only, so release needs no extra sequencing
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pc_reg <= `PCS_RST_PC;
      high_latch_reg <= `PCS_RST_HIGH_LATCH;
      page_en_reg <= `PCS_RST_FLOW_CFG;
      rsp_reg <= '0;
    end else begin
      pc_reg <= pc_next;
      high_latch_reg <= high_latch_next;
      page_en_reg <= page_en_next;
      rsp_reg <= rsp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack

  // Push saves the counter as it stands: the next instruction's address
  // Only decoded pushes and pops reach the pointer, never the bus
  // Limitation: stack contents survive reset; only the pointer clears
  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_WIDTH)
  ) return_stack_inst (
    .clk_i(MCLK_I),
    .arst_n_i(ARST_N_I),
    .ce_i(CE_I),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(pc_reg),
    .top_o(stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Counter leaves straight from its flip-flops
  assign PC_O = pc_reg;
  // Read data comes straight from the response flip-flops
  assign PRDATA_O = rsp_reg.rdata;
  // Error shows in the access phase only
  assign PSLVERR_O = rsp_reg.slverr && access;
  // Always ready; a frozen clock enable simply stretches nothing
  assign PREADY_O = 1'h1;

endmodule // program_counter_and_call_stack

// ### verification/pcs_monitor.sv
`timescale 1ns/1ns
// Port checker for counter sequencing
module pcs_monitor #(
  parameter logic [12:0] VECTOR_ADDR = 13'h0004,
  parameter bit PAGE_BITS_FITTED = 1'h0
) (
  input logic MCLK_I,
  input logic ARST_N_I,
  input logic CE_I,
  input logic STEP_I,
  input logic JUMP_I,
  input logic CALL_I,
  input logic RET_I,
  input logic VECTOR_I,
  input logic [10:0] TARGET_I,
  input logic [12:0] PC_O,
  input logic PSEL_I,
  input logic PENABLE_I,
  input logic PWRITE_I,
  input logic [11:0] PADDR_I,
  input logic [31:0] PWDATA_I,
  input logic [3:0] PSTRB_I,
  input logic PSLVERR_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  logic acc;
  logic lw;
  logic flow;
  // Flow ops outrank a low byte write
  assign acc = PSEL_I && PENABLE_I;
  assign lw = acc && PWRITE_I && PADDR_I == 12'h000 && PSTRB_I[0];
  assign flow = JUMP_I || CALL_I || RET_I || VECTOR_I;
  ////////////////
  a_step_adds_one: assert property (CE_I && STEP_I && !flow && !lw |=>
    PC_O == $past(PC_O) + 13'h0001) else $error("step did not add one");
  a_jump_target: assert property (CE_I && (JUMP_I || CALL_I) && !RET_I && !VECTOR_I
    |=> PC_O[10:0] == $past(TARGET_I) && (PAGE_BITS_FITTED || PC_O[12:11] == 2'h0))
    else $error("jump target wrong");
  a_call_return: assert property (CE_I && CALL_I && !RET_I && !VECTOR_I
    ##1 CE_I && RET_I && !VECTOR_I |=> PC_O == $past(PC_O, 2)) else $error("return wrong");
  a_vector_load: assert property (CE_I && VECTOR_I |=> PC_O == VECTOR_ADDR)
    else $error("vector not loaded");
  a_vector_return: assert property (CE_I && VECTOR_I ##1 CE_I && RET_I && !VECTOR_I
    |=> PC_O == $past(PC_O, 2)) else $error("interrupt return wrong");
  a_low_write: assert property (CE_I && lw && !flow |=> {24'h0, PC_O[7:0]} ==
    ($past(PWDATA_I) & 32'h0000_00ff)) else $error("low byte write lost");
  a_freeze_hold: assert property (!CE_I |=> $stable(PC_O))
    else $error("counter moved while frozen");
  a_idle_hold: assert property (CE_I && !flow && !STEP_I && !lw |=> $stable(PC_O))
    else $error("counter moved when idle");
  a_unmapped_err: assert property (acc && PADDR_I == 12'h00c && $past(CE_I) |->
    PSLVERR_O) else $error("unmapped access not refused");
  // Main scenarios reached
  c_call_ret: cover property (CALL_I ##1 RET_I);
  c_vector: cover property (VECTOR_I ##1 RET_I);
  c_low_write: cover property (lw && CE_I);
endmodule // pcs_monitor

bind program_counter_and_call_stack pcs_monitor #(
  .VECTOR_ADDR(VECTOR_ADDR),
  .PAGE_BITS_FITTED(PAGE_BITS_FITTED)
) pcs_monitor_inst (
  .MCLK_I, .ARST_N_I, .CE_I, .STEP_I, .JUMP_I, .CALL_I, .RET_I, .VECTOR_I, .TARGET_I,
  .PC_O, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I, .PSLVERR_O
);

// ### verification/core_flow_model.sv
`timescale 1ns/1ns
// Decoder and interrupt side, one request word per edge
module core_flow_model (
  input wire logic clk_i,
  output pc_stack_pkg::flow_req_s req_o
);
  // Quiet at start
  initial req_o = '0;
  // Strobes {step, jump, call, ret, vector}; page bits never sent
  task automatic issue(input logic [4:0] ops, input logic [10:0] t);
    @(posedge clk_i);
    req_o <= {ops, t};
  endtask
  // Drops strobes; stale target scrambled so nobody relies on it
  task automatic idle();
    @(posedge clk_i);
    req_o <= {5'h00, ~req_o.target};
  endtask
  // No low byte arithmetic here; table crossings stay software's care
endmodule // core_flow_model

// ### verification/program_counter_and_call_stack_test.sv
`timescale 1ns/1ns
// Request and register sequences with expected counter values
module program_counter_and_call_stack_test;
  localparam logic [4:0] OP_STEP = 5'h10;
  localparam logic [4:0] OP_JUMP = 5'h08;
  localparam logic [4:0] OP_CALL = 5'h04;
  localparam logic [4:0] OP_RET = 5'h02;
  localparam logic [4:0] OP_VEC = 5'h01;
  localparam logic [12:0] VEC_ADDR = 13'h0004;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ce = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic [12:0] pc;
  logic rdy;
  logic serr;
  logic err;
  logic [12:0] q[$];
  pc_stack_pkg::flow_req_s req;
  int mismatches = 0;
  int compares = 0;
  ////////////////
  // Core clock
  always #5 clk = ~clk;
  core_flow_model core_flow_model_inst (.clk_i(clk), .req_o(req));
  // Strobe tied to lane 0, the only lane in use
  program_counter_and_call_stack program_counter_and_call_stack_inst (
    .MCLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce), .STEP_I(req.step),
    .JUMP_I(req.jump), .CALL_I(req.call), .RET_I(req.ret),
    .VECTOR_I(req.vector), .TARGET_I(req.target), .PC_O(pc),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa),
    .PWDATA_I(pwd), .PSTRB_I(4'h1), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(serr)
  );
  ////////////////
  // One comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // APB transfer; request held until pready seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      give_verdict();
    end
    rd = prd;
    err = serr;
    psel <= 1'h0;
    pen <= 1'h0;
    #1;
  endtask
  // Ends a request burst and lets the counter settle
  task automatic fin();
    core_flow_model_inst.idle();
    #1;
  endtask
  ////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    check(32'(pc), 32'h0);
    check(32'(rdy), 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    apb(1'h1, 12'h004, 32'hffff_ff15);
    apb(1'h1, 12'h000, 32'hffff_ffa5);
    check(32'(pc), 32'h15a5);
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'ha5);
    $display("test low byte done");
    // Vector from a high page, then return at once
    core_flow_model_inst.issue(OP_VEC, 11'h000);
    core_flow_model_inst.issue(OP_RET, 11'h000);
    #1;
    check(32'(pc), 32'(VEC_ADDR));
    fin();
    check(32'(pc), 32'h15a5);
    // Page enable set; this variant still ignores the latch page bits
    apb(1'h1, 12'h008, 32'h0000_0001);
    apb(1'h0, 12'h008, 32'h0);
    check(rd, 32'h1);
    // Latch page bits 10 must not reach the target
    core_flow_model_inst.issue(OP_JUMP, 11'h7ff);
    core_flow_model_inst.issue(OP_STEP, 11'h000);
    fin();
    check(32'(pc), 32'h0800);
    $display("test vector and jump done");
    // Nine calls wrap the eight-deep stack
    for (int i = 1; i <= 9; i++) begin
      q.push_back(i == 1 ? 13'h0800 : 13'h0100 + 13'(i - 1));
      core_flow_model_inst.issue(OP_CALL, 11'h100 + 11'(i));
    end
    fin();
    check(32'(pc), 32'h0109);
    for (int i = 0; i < 9; i++) begin
      core_flow_model_inst.issue(OP_RET, 11'h000);
      fin();
      check(32'(pc), 32'(q[i < 8 ? 8 - i : 8]));
    end
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h15);
    $display("test stack wrap done");
    // Frozen core ignores a step
    @(posedge clk);
    ce <= 1'h0;
    core_flow_model_inst.issue(OP_STEP, 11'h000);
    fin();
    check(32'(pc), 32'h0108);
    @(posedge clk);
    ce <= 1'h1;
    // No pointer or status behind an unmapped word
    apb(1'h0, 12'h00c, 32'h0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    apb(1'h1, 12'h00c, 32'hffff_ffff);
    check(32'(err), 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h15);
    $display("test freeze and unmapped done");
    // Second reset mid-run clears counter and latch
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    check(32'(pc), 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule // program_counter_and_call_stack_test
